//--- src/clp_pkg.sv
// Summary of operation
// - Code 1 to 7 written to command field starts it
// - Command field returns to zero at completion
// - Busy bit 8 high while command runs
// - Result-pending bit 9 high until results written
// - Arguments one and two in upper register
// - Results to argument one, error to bit seven
// - Lower register bits 15..10 read zero
// - Writing code zero does nothing
// - Code 1 rebuilds all lists, all free
// - Init needs all nodes configurable, else error
// - Reset runs init, panel reads init busy
// - Code 2 moves object to list tail
// - Code 3 allocates free head, returns number
// - Code 4 moves source before destination
// - Code 5 inserts free head before destination
// - Code 6 moves source after destination
// - Empty free list sets error, nothing done
// - Lists change only through panel commands
// - Code 7 inserts free head after destination
package clp_pkg;
	// Register indices and APB byte addresses (index times four)
	localparam logic [11:0] CLP_IDX_LO   = 12'h1C4;
	localparam logic [11:0] CLP_IDX_HI   = 12'h1C6;
	localparam logic [13:0] CLP_ADDR_LO  = {CLP_IDX_LO, 2'b00};
	localparam logic [13:0] CLP_ADDR_HI  = {CLP_IDX_HI, 2'b00};
	// Reset values
	localparam logic [15:0] CLP_LO_RST   = 16'h0301;
	localparam logic [15:0] CLP_HI_RST   = 16'h0000;
	// Field positions
	localparam int          CLP_BUSY_BIT = 8;
	localparam int          CLP_RBSY_BIT = 9;
	localparam int          CLP_ERR_BIT  = 7;
	// Command codes
	localparam logic [7:0]  CLP_CMD_NOP  = 8'h00;
	localparam logic [7:0]  CLP_CMD_INIT = 8'h01;
	localparam logic [7:0]  CLP_CMD_SALC = 8'h02;
	localparam logic [7:0]  CLP_CMD_DALC = 8'h03;
	localparam logic [7:0]  CLP_CMD_SBEF = 8'h04;
	localparam logic [7:0]  CLP_CMD_DBEF = 8'h05;
	localparam logic [7:0]  CLP_CMD_SAFT = 8'h06;
	localparam logic [7:0]  CLP_CMD_DAFT = 8'h07;
	// Object and list store sizes
	localparam int          CLP_NUM_OBJ  = 32;
	localparam int          CLP_OBJ_W    = 5;
	localparam int          CLP_NUM_LIST = 8;
	localparam int          CLP_LIST_W   = 3;
	localparam logic [4:0]  CLP_LAST_OBJ = 5'h1F;
	localparam logic [2:0]  CLP_LIST_FREE = 3'h0;

	typedef struct packed {
		logic                 v;
		logic [CLP_OBJ_W-1:0] idx;
	} clp_ptr_t;

	typedef struct packed {
		logic [CLP_LIST_W-1:0] list;
		clp_ptr_t              prev;
		clp_ptr_t              next;
	} clp_link_t;

	typedef struct packed {
		logic list;
		logic prev;
		logic next;
	} clp_wmask_t;

	typedef struct packed {
		logic        wr_lo;
		logic        wr_hi;
		logic [1:0]  strb;
		logic [15:0] wdata;
	} clp_regacc_t;
endpackage : clp_pkg

//--- src/clp_link_mem.sv
`timescale 1ns/1ps
module clp_link_mem
	import clp_pkg::*;
(
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// Read port
	input  wire logic                 rd_en,
	input  wire logic [CLP_OBJ_W-1:0] rd_addr,
	output clp_link_t                 rd_data,
	// Write port with per-field enables
	input  wire logic                 wr_en,
	input  wire logic [CLP_OBJ_W-1:0] wr_addr,
	input  clp_wmask_t                wr_mask,
	input  clp_link_t                 wr_data
);
	clp_link_t mem [CLP_NUM_OBJ];

	// Field writes; content is rebuilt by the init sequence after reset
	always_ff @(posedge pclk) begin
		if (wr_en && wr_mask.list) mem[wr_addr].list <= wr_data.list;
		if (wr_en && wr_mask.prev) mem[wr_addr].prev <= wr_data.prev;
		if (wr_en && wr_mask.next) mem[wr_addr].next <= wr_data.next;
	end

	// Registered read, held until the next read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : clp_link_mem

//--- src/clp_apb_slave.sv
`timescale 1ns/1ps
module clp_apb_slave
	import clp_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [13:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Register side
	input  wire logic [15:0] rd_lo,
	input  wire logic [15:0] rd_hi,
	output clp_regacc_t      acc
);
	logic hit_lo;
	logic hit_hi;
	logic done;

	// Decode and completing-edge strobes
	assign hit_lo    = (paddr == CLP_ADDR_LO);
	assign hit_hi    = (paddr == CLP_ADDR_HI);
	assign done      = psel && penable && pready;
	assign acc.wr_lo = done && pwrite && hit_lo;
	assign acc.wr_hi = done && pwrite && hit_hi;
	assign acc.strb  = pstrb[1:0];
	assign acc.wdata = pwdata[15:0];

	// One wait state so read data leave a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= !(hit_lo || hit_hi);
			if (hit_lo) prdata <= {16'h0000, rd_lo};
			else if (hit_hi) prdata <= {16'h0000, rd_hi};
			else prdata <= 32'h0000_0000;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule : clp_apb_slave

//--- src/clp_panel.sv
// Chosen here: the APB register port.
`timescale 1ns/1ps
module clp_panel
	import clp_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [13:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Node configuration state, one bit per node
	input  wire logic [4:0]  node_init,
	input  wire logic [4:0]  node_cce
);
	typedef enum logic [3:0] {
		S_IDLE, S_INIT, S_RD_SRC, S_UNL_P, S_UNL_N,
		S_RD_DST, S_LNK_A, S_LNK_B, S_LNK_C, S_DONE
	} clp_state_t;

	clp_state_t                           state_reg;
	logic [7:0]                           cmd_reg;
	logic [7:0]                           arg1_reg;
	logic [7:0]                           arg2_reg;
	logic                                 result_pending_flag_reg;
	logic                                 err_reg;
	logic [CLP_OBJ_W-1:0]                 obj_reg;
	logic [CLP_OBJ_W-1:0]                 dst_reg;
	logic [CLP_OBJ_W-1:0]                 init_cnt_reg;
	clp_ptr_t [CLP_NUM_LIST-1:0]          head_reg;
	clp_ptr_t [CLP_NUM_LIST-1:0]          tail_reg;
	clp_regacc_t                          acc;
	clp_link_t                            rdata;
	logic                                 mem_rd_en;
	logic [CLP_OBJ_W-1:0]                 mem_rd_addr;
	logic                                 mem_wr_en;
	logic [CLP_OBJ_W-1:0]                 mem_wr_addr;
	clp_wmask_t                           mem_wr_mask;
	clp_link_t                            mem_wr_data;
	logic                                 busy;
	logic                                 nodes_ok;
	logic                                 start;
	logic [7:0]                           new_code;
	logic                                 is_append;
	logic                                 is_after;
	logic                                 is_dyn;
	logic [CLP_LIST_W-1:0]                dst_l;
	logic [15:0]                          rd_lo;
	logic [15:0]                          rd_hi;

	////////////////////////////////////////////////////////////////////////////
	// Bus slave and link store

	clp_apb_slave u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pstrb   (pstrb),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.rd_lo   (rd_lo),
		.rd_hi   (rd_hi),
		.acc     (acc)
	);

	clp_link_mem u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.rd_en   (mem_rd_en),
		.rd_addr (mem_rd_addr),
		.rd_data (rdata),
		.wr_en   (mem_wr_en),
		.wr_addr (mem_wr_addr),
		.wr_mask (mem_wr_mask),
		.wr_data (mem_wr_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Decode of the running command

	// Readback; reserved upper bits tied low
	assign busy     = (state_reg != S_IDLE);
	assign rd_lo    = {6'h00, result_pending_flag_reg, busy, cmd_reg};
	assign rd_hi    = {arg2_reg, arg1_reg};
	assign nodes_ok = &(node_init & node_cce);
	assign new_code = acc.wdata[7:0];
	// Codes above the last command are ignored like the no-operation code
	assign start    = acc.wr_lo && acc.strb[0] && !busy && (new_code != CLP_CMD_NOP) &&
	                  (new_code <= CLP_CMD_DAFT);
	assign is_append = (cmd_reg == CLP_CMD_SALC) || (cmd_reg == CLP_CMD_DALC);
	assign is_after  = (cmd_reg == CLP_CMD_SAFT) || (cmd_reg == CLP_CMD_DAFT);
	assign is_dyn    = (cmd_reg == CLP_CMD_DALC) || (cmd_reg == CLP_CMD_DBEF) || (cmd_reg == CLP_CMD_DAFT);
	assign dst_l     = dst_reg[CLP_LIST_W-1:0];

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	// Reset starts in the init state so the lists come up rebuilt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= S_INIT;
		end else begin
			unique case (state_reg)
				S_IDLE: begin
					if (start) begin
						if (new_code == CLP_CMD_INIT) state_reg <= nodes_ok ? S_INIT : S_DONE;
						else if (new_code[0] && new_code != CLP_CMD_INIT && !head_reg[0].v)
							state_reg <= S_DONE;
						else state_reg <= S_RD_SRC;
					end
				end
				S_INIT:   if (init_cnt_reg == CLP_LAST_OBJ) state_reg <= S_DONE;
				S_RD_SRC: state_reg <= S_UNL_P;
				S_UNL_P:  state_reg <= S_UNL_N;
				S_UNL_N:  state_reg <= is_append ? S_LNK_A : S_RD_DST;
				S_RD_DST: state_reg <= S_LNK_A;
				S_LNK_A:  state_reg <= (is_append && !tail_reg[dst_l].v) ? S_DONE : S_LNK_B;
				S_LNK_B:  state_reg <= is_append ? S_DONE : S_LNK_C;
				S_LNK_C:  state_reg <= S_DONE;
				S_DONE:   state_reg <= S_IDLE;
			endcase
		end
	end

	// Command field, result-pending flag, captured operands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg      <= CLP_LO_RST[7:0];
			result_pending_flag_reg    <= CLP_LO_RST[CLP_RBSY_BIT];
			err_reg      <= 1'b0;
			obj_reg      <= '0;
			dst_reg      <= '0;
			init_cnt_reg <= '0;
		end else if (state_reg == S_IDLE && start) begin
			cmd_reg      <= new_code;
			result_pending_flag_reg    <= new_code[0];
			err_reg      <= (new_code == CLP_CMD_INIT) ? !nodes_ok :
			                (new_code[0] && !head_reg[0].v);
			obj_reg      <= new_code[0] ? head_reg[0].idx : arg1_reg[CLP_OBJ_W-1:0];
			dst_reg      <= arg2_reg[CLP_OBJ_W-1:0];
			init_cnt_reg <= '0;
		end else if (state_reg == S_INIT) begin
			init_cnt_reg <= init_cnt_reg + 5'h01;
		end else if (state_reg == S_DONE) begin
			cmd_reg      <= CLP_CMD_NOP;
			result_pending_flag_reg    <= 1'b0;
		end
	end

	// Arguments: hardware results win over a same-cycle software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arg1_reg <= CLP_HI_RST[7:0];
			arg2_reg <= CLP_HI_RST[15:8];
		end else begin
			if (acc.wr_hi && acc.strb[0]) arg1_reg <= acc.wdata[7:0];
			if (acc.wr_hi && acc.strb[1]) arg2_reg <= acc.wdata[15:8];
			if (state_reg == S_DONE && cmd_reg[0]) begin
				arg2_reg[CLP_ERR_BIT] <= err_reg;
				if (is_dyn && !err_reg) arg1_reg <= {3'h0, obj_reg};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link store accesses per step

	// Unlink of the source, then link in at tail, before or after
	always_comb begin
		mem_rd_en   = 1'b0;
		mem_rd_addr = obj_reg;
		mem_wr_en   = 1'b0;
		mem_wr_addr = obj_reg;
		mem_wr_mask = '0;
		mem_wr_data = '0;
		unique case (state_reg)
			S_INIT: begin
				mem_wr_en            = 1'b1;
				mem_wr_addr          = init_cnt_reg;
				mem_wr_mask          = '1;
				mem_wr_data.list     = CLP_LIST_FREE;
				mem_wr_data.prev.v   = (init_cnt_reg != 5'h00);
				mem_wr_data.prev.idx = init_cnt_reg - 5'h01;
				mem_wr_data.next.v   = (init_cnt_reg != CLP_LAST_OBJ);
				mem_wr_data.next.idx = init_cnt_reg + 5'h01;
			end
			S_RD_SRC: mem_rd_en = 1'b1;
			S_UNL_P: begin
				mem_wr_en        = rdata.prev.v;
				mem_wr_addr      = rdata.prev.idx;
				mem_wr_mask.next = 1'b1;
				mem_wr_data.next = rdata.next;
			end
			S_UNL_N: begin
				mem_wr_en        = rdata.next.v;
				mem_wr_addr      = rdata.next.idx;
				mem_wr_mask.prev = 1'b1;
				mem_wr_data.prev = rdata.prev;
			end
			S_RD_DST: begin
				mem_rd_en   = 1'b1;
				mem_rd_addr = dst_reg;
			end
			S_LNK_A: begin
				mem_wr_en = 1'b1;
				if (is_append && tail_reg[dst_l].v) begin
					mem_wr_addr      = tail_reg[dst_l].idx;
					mem_wr_mask.next = 1'b1;
					mem_wr_data.next = {1'b1, obj_reg};
				end else if (is_append) begin
					mem_wr_mask      = '1;
					mem_wr_data.list = dst_l;
				end else begin
					mem_wr_mask      = '1;
					mem_wr_data.list = rdata.list;
					mem_wr_data.prev = is_after ? {1'b1, dst_reg} : rdata.prev;
					mem_wr_data.next = is_after ? rdata.next : {1'b1, dst_reg};
				end
			end
			S_LNK_B: begin
				mem_wr_en = 1'b1;
				if (is_append) begin
					mem_wr_mask      = '1;
					mem_wr_data.list = dst_l;
					mem_wr_data.prev = tail_reg[dst_l];
				end else begin
					mem_wr_addr      = dst_reg;
					mem_wr_mask.next = is_after;
					mem_wr_mask.prev = !is_after;
					mem_wr_data.next = {1'b1, obj_reg};
					mem_wr_data.prev = {1'b1, obj_reg};
				end
			end
			S_LNK_C: begin
				mem_wr_en        = is_after ? rdata.next.v : rdata.prev.v;
				mem_wr_addr      = is_after ? rdata.next.idx : rdata.prev.idx;
				mem_wr_mask.prev = is_after;
				mem_wr_mask.next = !is_after;
				mem_wr_data.prev = {1'b1, obj_reg};
				mem_wr_data.next = {1'b1, obj_reg};
			end
			S_IDLE, S_DONE: begin
			end
		endcase
	end

	// List heads and tails; only the sequencer touches them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			head_reg <= '0;
			tail_reg <= '0;
		end else begin
			if (state_reg == S_INIT && init_cnt_reg == CLP_LAST_OBJ) begin
				head_reg    <= '0;
				tail_reg    <= '0;
				head_reg[0] <= {1'b1, 5'h00};
				tail_reg[0] <= {1'b1, CLP_LAST_OBJ};
			end
			if (state_reg == S_UNL_P && !rdata.prev.v) head_reg[rdata.list] <= rdata.next;
			if (state_reg == S_UNL_N && !rdata.next.v) tail_reg[rdata.list] <= rdata.prev;
			if (state_reg == S_LNK_A && is_append && !tail_reg[dst_l].v) begin
				head_reg[dst_l] <= {1'b1, obj_reg};
				tail_reg[dst_l] <= {1'b1, obj_reg};
			end
			if (state_reg == S_LNK_B && is_append) tail_reg[dst_l] <= {1'b1, obj_reg};
			if (state_reg == S_LNK_C && is_after && !rdata.next.v) tail_reg[rdata.list] <= {1'b1, obj_reg};
			if (state_reg == S_LNK_C && !is_after && !rdata.prev.v) head_reg[rdata.list] <= {1'b1, obj_reg};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_start_cmd;
		(state_reg == S_IDLE) && start;
	endsequence

	sequence s_run_to_end;
		busy ##[1:40] !busy;
	endsequence

	sequence s_quick_end;
		(state_reg == S_DONE) ##1 (state_reg == S_IDLE);
	endsequence

	property p_start_runs;
		s_start_cmd |=> s_run_to_end;
	endproperty
	a_start_runs: assert property (p_start_runs) else $error("accepted command did not run and finish");

	property p_cmd_clear;
		(state_reg == S_DONE) |=> (cmd_reg == CLP_CMD_NOP) && !busy;
	endproperty
	a_cmd_clear: assert property (p_cmd_clear) else $error("command field not cleared at end");

	property p_result_pending_flag_in_busy;
		result_pending_flag_reg |-> busy;
	endproperty
	a_result_pending_flag_in_busy: assert property (p_result_pending_flag_in_busy) else $error("result pending while idle");

	property p_nop_ignored;
		(state_reg == S_IDLE && acc.wr_lo && acc.strb[0] && new_code == CLP_CMD_NOP)
			|=> (state_reg == S_IDLE) && (cmd_reg == CLP_CMD_NOP);
	endproperty
	a_nop_ignored: assert property (p_nop_ignored) else $error("zero code started something");

	property p_rsvd_zero;
		(pready && psel && paddr == CLP_ADDR_LO) |-> (prdata[15:10] == 6'h00);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

	property p_init_lists;
		(state_reg == S_DONE && $past(state_reg) == S_INIT)
			|-> (head_reg[0] == {1'b1, 5'h00}) && (tail_reg[0] == {1'b1, CLP_LAST_OBJ}) && !head_reg[1].v;
	endproperty
	a_init_lists: assert property (p_init_lists) else $error("lists not rebuilt by init");

	property p_init_len;
		(state_reg == S_INIT && init_cnt_reg == 5'h00) |-> ##[32:33] (state_reg == S_DONE);
	endproperty
	a_init_len: assert property (p_init_len) else $error("init sequence length wrong");

	property p_init_refused;
		(s_start_cmd and (new_code == CLP_CMD_INIT && !nodes_ok)) |=> s_quick_end ##0 arg2_reg[CLP_ERR_BIT];
	endproperty
	a_init_refused: assert property (p_init_refused) else $error("init without nodes ready not flagged");

	property p_empty_free;
		(s_start_cmd and (new_code[0] && new_code != CLP_CMD_INIT && !head_reg[0].v))
			|=> s_quick_end ##0 arg2_reg[CLP_ERR_BIT];
	endproperty
	a_empty_free: assert property (p_empty_free) else $error("empty free list not flagged");

	property p_dyn_result;
		(state_reg == S_DONE && is_dyn && !err_reg) |=> (arg1_reg == {3'h0, $past(obj_reg)}) && !arg2_reg[CLP_ERR_BIT];
	endproperty
	a_dyn_result: assert property (p_dyn_result) else $error("allocated object number not returned");

	property p_static_tail;
		(state_reg == S_DONE && cmd_reg == CLP_CMD_SALC) |-> (tail_reg[dst_l] == {1'b1, obj_reg});
	endproperty
	a_static_tail: assert property (p_static_tail) else $error("object not at list tail");

	property p_lists_frozen;
		(state_reg == S_IDLE) |=> $stable(head_reg) && $stable(tail_reg);
	endproperty
	a_lists_frozen: assert property (p_lists_frozen) else $error("lists changed while idle");
endmodule : clp_panel

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import clp_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [13:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [4:0]  node_init;
	logic [4:0]  node_cce;
	int          errors;
	int          samples_checked;
	int          cycles;
	int          freeq[$];
	logic [15:0] hi;
	logic [31:0] rd;
	logic        se;
	logic [7:0]  lst;
	logic [7:0]  code;
	logic [7:0]  last;
	logic [7:0]  trio [3];

	clp_panel dut (
		.pclk      (pclk),
		.presetn   (presetn),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.pstrb     (pstrb),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.node_init (node_init),
		.node_cce  (node_cce)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock at 25 MHz
	initial pclk = 1'b0;
	always #20 pclk = ~pclk;

	// Hang guard: the whole run needs about 1200 cycles
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; entered just after a rising edge, leaves one idle edge
	// Waits on pready with no limit of its own; the hang guard ends a stuck wait
	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Arguments first, then the code; poll busy, return the argument word
	task automatic cmd(input logic [7:0] c, input logic [7:0] a1, input logic [7:0] a2,
		input bit experr, output logic [15:0] h);
		logic [31:0] r;
		logic        e;
		apb(1'b1, CLP_ADDR_HI, {16'h0000, a2, a1}, r, e);
		apb(1'b1, CLP_ADDR_LO, {24'h000000, c}, r, e);
		apb(1'b0, CLP_ADDR_LO, 32'h00000000, r, e);
		if (!experr) begin
			check({15'h0000, r[CLP_BUSY_BIT]}, 16'h0001);
			check({15'h0000, r[CLP_RBSY_BIT]}, {15'h0000, c[0]});
		end
		// Results are only trusted once busy and result-pending have dropped
		while (r[CLP_BUSY_BIT] !== 1'b0 || r[CLP_RBSY_BIT] !== 1'b0) begin
			apb(1'b0, CLP_ADDR_LO, 32'h00000000, r, e);
		end
		check(r[15:0], 16'h0000);
		apb(1'b0, CLP_ADDR_HI, 32'h00000000, r, e);
		h = r[15:0];
		check({15'h0000, h[CLP_ERR_BIT+8]}, {15'h0000, experr});
	endtask : cmd

	// Free list model: move src next to dst
	task automatic place(input int src, input int dst, input bit after);
		int i;
		for (i = 0; i < freeq.size(); i++) begin
			if (freeq[i] == dst) begin
				break;
			end
		end
		freeq.insert(after ? i + 1 : i, src);
	endtask : place

	////////////////////////////////////////////////////////////////////////
	initial begin
		errors = 0;
		samples_checked = 0;
		cycles = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 14'h0000;
		pwdata = 32'h00000000;
		pstrb = 4'h0;
		node_init = 5'h00;
		node_cce = 5'h00;
		void'($urandom(15044));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Automatic init shows up in the reset value
		apb(1'b0, CLP_ADDR_LO, 32'h00000000, rd, se);
		check(rd[15:0], CLP_LO_RST);
		repeat (40) @(posedge pclk);
		apb(1'b0, CLP_ADDR_LO, 32'h00000000, rd, se);
		check(rd[15:0], 16'h0000);
		apb(1'b0, CLP_ADDR_HI, 32'h00000000, rd, se);
		check(rd[15:0], CLP_HI_RST);
		for (int i = 0; i < CLP_NUM_OBJ; i++) freeq.push_back(i);
		// Argument word is plain read/write storage
		hi = 16'($urandom);
		apb(1'b1, CLP_ADDR_HI, {16'h0000, hi}, rd, se);
		apb(1'b0, CLP_ADDR_HI, 32'h00000000, rd, se);
		check(rd[15:0], hi);
		// Null and reserved codes start nothing; top bits read zero
		trio = '{8'h00, 8'h08, 8'hFF};
		foreach (trio[k]) begin
			code = trio[k];
			apb(1'b1, CLP_ADDR_LO, {16'h0000, 8'h00, code}, rd, se);
			apb(1'b0, CLP_ADDR_LO, 32'h00000000, rd, se);
			check(rd[15:0], 16'h0000);
		end
		apb(1'b0, CLP_ADDR_HI, 32'h00000000, rd, se);
		check(rd[15:0], hi);
		// Unmapped address answers with an error
		apb(1'b0, 14'h0004, 32'h00000000, rd, se);
		check({15'h0000, se}, 16'h0001);
		// Init refused while some node is not configurable
		node_init <= 5'($urandom_range(0, 30));
		node_cce  <= 5'($urandom);
		@(posedge pclk);
		cmd(CLP_CMD_INIT, 8'h00, 8'h00, 1'b1, hi);
		// Drain the free list with codes 3, 5 and 7
		lst = 8'($urandom_range(1, 7));
		last = 8'h00;
		for (int i = 0; i < CLP_NUM_OBJ; i++) begin
			code = (i % 3 == 0) ? CLP_CMD_DALC : ((i % 3 == 1) ? CLP_CMD_DBEF : CLP_CMD_DAFT);
			cmd(code, 8'h00, (code == CLP_CMD_DALC) ? lst : last, 1'b0, hi);
			check({11'h000, hi[4:0]}, 16'(freeq.pop_front()));
			last = {3'h0, hi[4:0]};
		end
		// Empty free list: every dynamic command reports an error
		trio = '{CLP_CMD_DALC, CLP_CMD_DBEF, CLP_CMD_DAFT};
		foreach (trio[k]) begin
			cmd(trio[k], 8'h00, last, 1'b1, hi);
		end
		// Static moves reshape the free list, seen through allocation order
		cmd(CLP_CMD_SALC, 8'd5, 8'h00, 1'b0, hi);
		freeq.push_back(5);
		cmd(CLP_CMD_SALC, 8'd9, 8'h00, 1'b0, hi);
		freeq.push_back(9);
		cmd(CLP_CMD_SBEF, 8'd12, 8'd5, 1'b0, hi);
		place(12, 5, 1'b0);
		cmd(CLP_CMD_SAFT, 8'd20, 8'd12, 1'b0, hi);
		place(20, 12, 1'b1);
		while (freeq.size() > 0) begin
			cmd(CLP_CMD_DALC, 8'h00, lst, 1'b0, hi);
			check({11'h000, hi[4:0]}, 16'(freeq.pop_front()));
		end
		cmd(CLP_CMD_DALC, 8'h00, lst, 1'b1, hi);
		// Init with all nodes ready restores the free list 0..31
		node_init <= 5'h1F;
		node_cce  <= 5'h1F;
		@(posedge pclk);
		cmd(CLP_CMD_INIT, 8'h00, 8'h00, 1'b0, hi);
		for (int i = 0; i < CLP_NUM_OBJ; i++) freeq.push_back(i);
		repeat (2) begin
			cmd(CLP_CMD_DALC, 8'h00, 8'($urandom_range(1, 7)), 1'b0, hi);
			check({11'h000, hi[4:0]}, 16'(freeq.pop_front()));
		end
		conclude();
	end
endmodule : testbench
